// file: hdl/aes_engine.sv
// block crypto engine: 128-bit key and state memories, one round per cycle
// assumes synchronous byte writes from a bus master; results are held
// back until the fixed block time has run out
`timescale 1ns/1ps
`include "aes_consts.svh"
module aes_engine (
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // memory loading and readback
  input wire aes_pkg::aes_wr_s key_wr,
  input wire aes_pkg::aes_wr_s st_wr,
  input wire logic [3:0] st_rd_addr,
  output logic [7:0] st_rd_data,
  // control
  input wire logic start,
  input wire logic decrypt,
  input wire logic auto_start,
  input wire logic xor_load,
  input wire logic irq_en,
  // status
  output logic busy,
  output logic done,
  output logic irq,
  output logic dma_trig
);
  import aes_pkg::*;

  aes_state_e fsm_reg;
  aes_block_t key_reg;
  aes_block_t st_reg;
  aes_block_t wk_reg;
  logic [8:0] cnt_reg;
  logic [3:0] rnd_reg;
  logic [7:0] rcon_reg;
  logic dec_reg;
  logic busy_reg;
  logic done_reg;
  logic irq_reg;
  logic dma_reg;
  logic [7:0] rd_reg;
  logic go;
  logic last;
  logic bwd;
  logic [7:0] rcon_use;
  aes_block_t sub;
  aes_block_t key_next;
  aes_block_t round_out;
  logic [3:0][7:0] kin;
  logic [3:0][7:0] ks;

  function automatic logic [7:0] xtime(input logic [7:0] a);
    return a[7] ? ({a[6:0], 1'b0} ^ `AES_POLY) : {a[6:0], 1'b0};
  endfunction

  function automatic logic [7:0] inv_xtime(input logic [7:0] a);
    return a[0] ? ({1'b1, a[7:1]} ^ (`AES_POLY >> 1)) : {1'b0, a[7:1]};
  endfunction

  function automatic logic [7:0] gmul(input logic [7:0] a,
                                      input logic [3:0] b);
    logic [7:0] p;
    logic [7:0] x;
    p = 8'h_00;
    x = a;
    for (int i = 0; i < 4; i++) begin
      if (b[i]) begin
        p = p ^ x;
      end
      x = xtime(x);
    end
    return p;
  endfunction

  // ----------------------------------------------------------------
  // start decode; loads and starts are only honoured while idle
  // ----------------------------------------------------------------
  assign go = (fsm_reg == ST_IDLE) &&
              (start || (auto_start && st_wr.en &&
                         st_wr.addr == `AES_LAST_BYTE));
  assign last = (rnd_reg == `AES_LAST_RND);
  // decryption walks the schedule forward first, backward only in rounds
  assign bwd = dec_reg && (fsm_reg != ST_EXPAND);
  assign rcon_use = bwd ? inv_xtime(rcon_reg) : rcon_reg;

  // ----------------------------------------------------------------
  // substitution units: sixteen on the state, four on the key word
  // ----------------------------------------------------------------
  for (genvar i = 0; i < 16; i++) begin : g_st_sbox
    aes_sbox u_sbox (
      .in_byte(st_reg[i]),
      .inv(dec_reg),
      .out_byte(sub[i])
    );
  end

  for (genvar i = 0; i < 4; i++) begin : g_key_sbox
    // rotword folded in: byte i of the substituted word reads byte i+1
    assign kin[i] = bwd ? (wk_reg[12 + ((i + 1) % 4)] ^
                               wk_reg[8 + ((i + 1) % 4)])
                            : wk_reg[12 + ((i + 1) % 4)];
    aes_sbox u_sbox (
      .in_byte(kin[i]),
      .inv(1'b0),
      .out_byte(ks[i])
    );
  end

  // ----------------------------------------------------------------
  // key schedule step, forward or backward by one round
  // ----------------------------------------------------------------
  always_comb begin
    logic [3:0][7:0] t;
    t = ks;
    t[0] = ks[0] ^ rcon_use;
    key_next = wk_reg;
    if (bwd) begin
      for (int b = 15; b >= 4; b--) begin
        key_next[b] = wk_reg[b] ^ wk_reg[b - 4];
      end
      for (int b = 0; b < 4; b++) begin
        key_next[b] = wk_reg[b] ^ t[b];
      end
    end else begin
      for (int b = 0; b < 4; b++) begin
        key_next[b] = wk_reg[b] ^ t[b];
      end
      for (int b = 4; b < 16; b++) begin
        key_next[b] = wk_reg[b] ^ key_next[b - 4];
      end
    end
  end

  // ----------------------------------------------------------------
  // one full round; the last round skips the column mix
  // ----------------------------------------------------------------
  always_comb begin
    aes_block_t sh;
    aes_block_t t;
    sh = sub;
    t = sub;
    round_out = sub;
    for (int r = 0; r < 4; r++) begin
      for (int c = 0; c < 4; c++) begin
        sh[r + 4 * c] = dec_reg ? sub[r + 4 * ((c - r + 4) % 4)]
                                : sub[r + 4 * ((c + r) % 4)];
      end
    end
    t = dec_reg ? (sh ^ key_next) : sh;
    for (int c = 0; c < 4; c++) begin
      for (int r = 0; r < 4; r++) begin
        if (dec_reg) begin
          round_out[r + 4 * c] =
            gmul(t[4 * c + r], 4'h_e) ^
            gmul(t[4 * c + (r + 1) % 4], 4'h_b) ^
            gmul(t[4 * c + (r + 2) % 4], 4'h_d) ^
            gmul(t[4 * c + (r + 3) % 4], 4'h_9);
        end else begin
          round_out[r + 4 * c] =
            gmul(t[4 * c + r], 4'h_2) ^
            gmul(t[4 * c + (r + 1) % 4], 4'h_3) ^
            t[4 * c + (r + 2) % 4] ^ t[4 * c + (r + 3) % 4];
        end
      end
    end
    if (last) begin
      round_out = t;
    end
    if (!dec_reg) begin
      round_out = round_out ^ key_next;
    end
  end

  // ----------------------------------------------------------------
  // key memory: user copy survives the run, the schedule uses wk_reg
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      key_reg <= '0;
    end else if (fsm_reg == ST_IDLE && key_wr.en) begin
      key_reg[key_wr.addr] <= key_wr.data;
    end
  end

  // ----------------------------------------------------------------
  // state memory: byte loads while idle, rounds while running
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      st_reg <= '0;
    end else if (fsm_reg == ST_IDLE && st_wr.en) begin
      st_reg[st_wr.addr] <= xor_load ? (st_reg[st_wr.addr] ^ st_wr.data)
                                     : st_wr.data;
    end else if (fsm_reg == ST_WHITEN) begin
      st_reg <= st_reg ^ wk_reg;
    end else if (fsm_reg == ST_ROUND) begin
      st_reg <= round_out;
    end
  end

  // ----------------------------------------------------------------
  // sequencer; decryption first walks the schedule to the last key
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      fsm_reg <= ST_IDLE;
      wk_reg <= '0;
      rnd_reg <= 4'h_0;
      rcon_reg <= `AES_RCON_INIT;
      dec_reg <= 1'b0;
    end else begin
      case (fsm_reg)
        ST_IDLE: begin
          if (go) begin
            dec_reg <= decrypt;
            wk_reg <= key_reg;
            rnd_reg <= 4'h_0;
            rcon_reg <= `AES_RCON_INIT;
            fsm_reg <= decrypt ? ST_EXPAND : ST_WHITEN;
          end
        end
        ST_EXPAND: begin
          // runs the forward schedule although dec_reg is set
          wk_reg <= key_next;
          rcon_reg <= xtime(rcon_reg);
          rnd_reg <= last ? 4'h_0 : 4'(rnd_reg + 4'h_1);
          fsm_reg <= last ? ST_WHITEN : ST_EXPAND;
        end
        ST_WHITEN: begin
          fsm_reg <= ST_ROUND;
        end
        ST_ROUND: begin
          wk_reg <= key_next;
          rcon_reg <= dec_reg ? rcon_use : xtime(rcon_reg);
          rnd_reg <= 4'(rnd_reg + 4'h_1);
          fsm_reg <= last ? ST_HOLD : ST_ROUND;
        end
        ST_HOLD: begin
          if (cnt_reg == `AES_LAST_CNT) begin
            fsm_reg <= ST_IDLE;
          end
        end
        default: begin
          fsm_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // block timer, busy and completion events
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      cnt_reg <= 9'h_000;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
      irq_reg <= 1'b0;
      dma_reg <= 1'b0;
    end else begin
      irq_reg <= 1'b0;
      dma_reg <= 1'b0;
      if (go) begin
        cnt_reg <= 9'h_000;
        busy_reg <= 1'b1;
        done_reg <= 1'b0;
      end else if (busy_reg) begin
        cnt_reg <= 9'(cnt_reg + 9'h_001);
        if (cnt_reg == `AES_LAST_CNT) begin
          busy_reg <= 1'b0;
          done_reg <= 1'b1;
          irq_reg <= irq_en;
          dma_reg <= 1'b1;
        end
      end
    end
  end

  // the half-finished state never leaves the block
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      rd_reg <= 8'h_00;
    end else begin
      rd_reg <= busy_reg ? 8'h_00 : st_reg[st_rd_addr];
    end
  end

  assign st_rd_data = rd_reg;
  assign busy = busy_reg;
  assign done = done_reg;
  assign irq = irq_reg;
  assign dma_trig = dma_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_finish;
    !busy_reg && done_reg && dma_reg;
  endsequence

  chk_block_time: assert property (@(posedge mclk) disable iff (!rstn)
    $fell(busy_reg) |-> $past(cnt_reg) == `AES_LAST_CNT)
    else $error("block time wrong");
  chk_finish_step: assert property (@(posedge mclk) disable iff (!rstn)
    busy_reg && cnt_reg == `AES_LAST_CNT |=> s_finish)
    else $error("completion step wrong");
  chk_irq_gate: assert property (@(posedge mclk) disable iff (!rstn)
    $rose(done_reg) |-> irq_reg == $past(irq_en))
    else $error("irq does not follow enable");
  chk_dma_once: assert property (@(posedge mclk) disable iff (!rstn)
    dma_reg |=> !dma_reg)
    else $error("dma trigger longer than a pulse");
  chk_auto_go: assert property (@(posedge mclk) disable iff (!rstn)
    fsm_reg == ST_IDLE && auto_start && st_wr.en &&
    st_wr.addr == `AES_LAST_BYTE |=> busy_reg && !done_reg)
    else $error("auto start missed");
  chk_xor_load: assert property (@(posedge mclk) disable iff (!rstn)
    fsm_reg == ST_IDLE && st_wr.en && xor_load |=>
    st_reg[$past(st_wr.addr)] ==
    ($past(st_reg[st_wr.addr]) ^ $past(st_wr.data)))
    else $error("xor load wrong");
  chk_start_busy: assert property (@(posedge mclk) disable iff (!rstn)
    go |=> busy_reg && !done_reg ##1 busy_reg[*8])
    else $error("busy not held after start");
  chk_rounds_done: assert property (@(posedge mclk) disable iff (!rstn)
    fsm_reg == ST_HOLD |-> rnd_reg == `AES_ROUNDS)
    else $error("round count wrong");
  chk_read_hidden: assert property (@(posedge mclk) disable iff (!rstn)
    busy_reg |=> st_rd_data == 8'h_00)
    else $error("state visible while busy");

endmodule

// file: common/aes_consts.svh
// constants of the block crypto engine: byte indices, counts, fixed values
// assumes a 40 MHz mclk; all counts are in mclk cycles
`ifndef AES_CONSTS_SVH
`define AES_CONSTS_SVH

// ----------------------------------------------------------------
// block geometry
// ----------------------------------------------------------------
`define AES_BYTES 16
`define AES_LAST_BYTE 4'h_f

// ----------------------------------------------------------------
// timing: a block occupies the engine for this many cycles
// ----------------------------------------------------------------
`define AES_BLOCK_CYCLES 375
`define AES_LAST_CNT 9'h_176
`define AES_ROUNDS 4'h_a
`define AES_LAST_RND 4'h_9

// ----------------------------------------------------------------
// field constants
// ----------------------------------------------------------------
`define AES_RCON_INIT 8'h_01
`define AES_POLY 8'h_1b
`define AES_AFF_FWD 8'h_63
`define AES_AFF_INV 8'h_05

`endif

// file: common/aes_pkg.sv
// types shared by the block crypto engine and its testbench
// assumes nothing of its surroundings
package aes_pkg;

  // one byte write into the key or the state memory
  typedef struct packed {
    logic en;
    logic [3:0] addr;
    logic [7:0] data;
  } aes_wr_s;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_EXPAND,
    ST_WHITEN,
    ST_ROUND,
    ST_HOLD
  } aes_state_e;

  typedef logic [15:0][7:0] aes_block_t;

endpackage

// file: hdl/aes_sbox.sv
// one byte substitution, forward or inverse, built from the field inverse
// assumes a purely combinational use; inv selects the inverse box
`timescale 1ns/1ps
`include "aes_consts.svh"
module aes_sbox (
  // byte in and out
  input wire logic [7:0] in_byte,
  input wire logic inv,
  output logic [7:0] out_byte
);

  function automatic logic [7:0] gmul(input logic [7:0] a,
                                      input logic [7:0] b);
    logic [7:0] p;
    logic [7:0] x;
    p = 8'h_00;
    x = a;
    for (int i = 0; i < 8; i++) begin
      if (b[i]) begin
        p = p ^ x;
      end
      x = x[7] ? ({x[6:0], 1'b0} ^ `AES_POLY) : {x[6:0], 1'b0};
    end
    return p;
  endfunction

  function automatic logic [7:0] rotl(input logic [7:0] v, input int n);
    return 8'((v << n) | (v >> (8 - n)));
  endfunction

  logic [7:0] pre;
  logic [7:0] finv;

  // ----------------------------------------------------------------
  // inverse affine first on the inverse path, field inverse, then affine on the forward path
  // ----------------------------------------------------------------
  always_comb begin
    logic [7:0] p;
    logic [7:0] r;
    p = 8'h_00;
    r = 8'h_01;
    if (inv) begin
      pre = rotl(in_byte, 1) ^ rotl(in_byte, 3) ^ rotl(in_byte, 6)
            ^ `AES_AFF_INV;
    end else begin
      pre = in_byte;
    end
    // x^254 by square and multiply; zero maps to zero by itself
    p = pre;
    for (int i = 0; i < 7; i++) begin
      p = gmul(p, p);
      r = gmul(r, p);
    end
    finv = r;
    if (inv) begin
      out_byte = finv;
    end else begin
      out_byte = finv ^ rotl(finv, 1) ^ rotl(finv, 2) ^ rotl(finv, 3)
                 ^ rotl(finv, 4) ^ `AES_AFF_FWD;
    end
  end

endmodule

// file: testbench/aes_host_model.sv
// bus master model: loads key and state bytes, starts and reads the engine
// assumes the engine samples its inputs on the rising edge of mclk
`timescale 1ns/1ps
module aes_host_model (
  // clock
  input wire logic mclk,
  // towards the engine
  output aes_pkg::aes_wr_s key_wr,
  output aes_pkg::aes_wr_s st_wr,
  output logic [3:0] st_rd_addr,
  output logic start,
  output logic decrypt,
  output logic auto_start,
  output logic xor_load,
  output logic irq_en,
  // from the engine
  input wire logic [7:0] st_rd_data
);
  import aes_pkg::*;

  initial begin
    key_wr = '0;
    st_wr = '0;
    st_rd_addr = 4'h_0;
    start = 1'b0;
    decrypt = 1'b0;
    auto_start = 1'b0;
    xor_load = 1'b0;
    irq_en = 1'b0;
  end

  // ----------------------------------------------------------------
  // loading
  // ----------------------------------------------------------------
  // a whole block, byte 0 first, before any start is issued
  task automatic load(input logic is_key, input logic [127:0] blk);
    aes_wr_s w;
    for (int i = 0; i < 16; i++) begin
      @(negedge mclk);
      w.en = 1'b1;
      w.addr = i[3:0];
      w.data = blk[127-8*i -: 8];
      if (is_key) key_wr = w;
      else st_wr = w;
    end
    @(negedge mclk);
    // a released data bus does not keep its last value
    key_wr.en = 1'b0;
    key_wr.data = ~key_wr.data;
    st_wr.en = 1'b0;
    st_wr.data = ~st_wr.data;
  endtask

  // ----------------------------------------------------------------
  // control and readback
  // ----------------------------------------------------------------
  task automatic set_mode(input logic au, xl, ie, dec);
    @(negedge mclk);
    auto_start = au;
    xor_load = xl;
    irq_en = ie;
    decrypt = dec;
  endtask

  task automatic start_op(input logic dec);
    @(negedge mclk);
    decrypt = dec;
    start = 1'b1;
    @(negedge mclk);
    start = 1'b0;
  endtask

  // data is registered, so it shows one cycle after the address
  task automatic read_byte(input logic [3:0] a, output logic [7:0] d);
    @(negedge mclk);
    st_rd_addr = a;
    @(negedge mclk);
    d = st_rd_data;
  endtask
endmodule

// file: testbench/aes_block_crypto_engine_test.sv
// self-checking bench for the block crypto engine with a host model
// assumes a 40 MHz mclk and the standard 128-bit test vector byte order
`timescale 1ns/1ps
module aes_block_crypto_engine_test;
  import aes_pkg::*;

  // ----------------------------------------------------------------
  // vectors: byte 0 is the leftmost pair of digits
  // ----------------------------------------------------------------
  localparam logic [127:0] KEY = 128'h_0001_0203_0405_0607_0809_0a0b_0c0d_0e0f;
  localparam logic [127:0] PT = 128'h_0011_2233_4455_6677_8899_aabb_ccdd_eeff;
  localparam logic [127:0] CT = 128'h_69c4_e0d8_6a7b_0430_d8cd_b780_70b4_c55a;
  localparam logic [127:0] MASK =
    128'h_0f1e_2d3c_4b5a_6978_8796_a5b4_c3d2_e1f0;

  logic mclk;
  logic rstn;
  aes_wr_s key_wr;
  aes_wr_s st_wr;
  logic [3:0] st_rd_addr;
  logic [7:0] st_rd_data;
  logic start, decrypt, auto_start, xor_load, irq_en;
  logic busy, done, irq, dma_trig;
  int num_errors = 0;
  int checked = 0;

  initial mclk = 1'b0;
  always #12.5 mclk = ~mclk;

  aes_engine dut (
    .mclk(mclk), .rstn(rstn), .key_wr(key_wr), .st_wr(st_wr),
    .st_rd_addr(st_rd_addr), .st_rd_data(st_rd_data), .start(start),
    .decrypt(decrypt), .auto_start(auto_start), .xor_load(xor_load),
    .irq_en(irq_en), .busy(busy), .done(done), .irq(irq),
    .dma_trig(dma_trig)
  );

  aes_host_model u_host (
    .mclk(mclk), .key_wr(key_wr), .st_wr(st_wr), .st_rd_addr(st_rd_addr),
    .start(start), .decrypt(decrypt), .auto_start(auto_start),
    .xor_load(xor_load), .irq_en(irq_en), .st_rd_data(st_rd_data)
  );

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [8:0] exp,
                     input logic [8:0] got);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic expect_block(input logic [127:0] exp);
    logic [7:0] d;
    for (int i = 0; i < 16; i++) begin
      u_host.read_byte(i[3:0], d);
      chk("state byte", {1'b0, exp[127-8*i -: 8]}, {1'b0, d});
    end
  endtask

  // entered at the first cycle after the start edge
  task automatic wait_done(input logic exp_irq);
    int n;
    n = 0;
    chk("busy at start", 9'h_001, {8'h_00, busy});
    chk("done cleared", 9'h_000, {8'h_00, done});
    while (busy === 1'b1 && n < 400) begin
      n++;
      @(negedge mclk);
    end
    if (n >= 400) begin
      num_errors++;
      close_out();
    end
    chk("busy cycles", 9'h_177, n[8:0]);
    chk("done", 9'h_001, {8'h_00, done});
    chk("dma trigger", 9'h_001, {8'h_00, dma_trig});
    chk("irq", {8'h_00, exp_irq}, {8'h_00, irq});
    @(negedge mclk);
    chk("dma trigger pulse", 9'h_000, {8'h_00, dma_trig});
    chk("irq pulse", 9'h_000, {8'h_00, irq});
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic test_reset();
    logic [7:0] d;
    chk("busy after reset", 9'h_000, {8'h_00, busy});
    chk("done after reset", 9'h_000, {8'h_00, done});
    chk("dma after reset", 9'h_000, {8'h_00, dma_trig});
    chk("irq after reset", 9'h_000, {8'h_00, irq});
    u_host.read_byte(4'h_0, d);
    chk("state after reset", 9'h_000, {1'b0, d});
    $display("test reset finished");
  endtask

  task automatic test_encrypt();
    u_host.set_mode(1'b0, 1'b0, 1'b1, 1'b0);
    u_host.load(1'b1, KEY);
    u_host.load(1'b0, PT);
    u_host.start_op(1'b0);
    wait_done(1'b1);
    expect_block(CT);
    $display("test encrypt finished");
  endtask

  // done is still set from the previous block, so its clearing shows
  task automatic test_decrypt();
    u_host.set_mode(1'b0, 1'b0, 1'b0, 1'b1);
    u_host.start_op(1'b1);
    wait_done(1'b0);
    expect_block(PT);
    $display("test decrypt finished");
  endtask

  task automatic test_xor();
    u_host.set_mode(1'b0, 1'b0, 1'b0, 1'b0);
    u_host.load(1'b0, PT);
    u_host.set_mode(1'b0, 1'b1, 1'b0, 1'b0);
    u_host.load(1'b0, MASK);
    expect_block(PT ^ MASK);
    $display("test xor load finished");
  endtask

  // the block must start on the edge that takes byte 15, with no start
  task automatic test_auto();
    u_host.set_mode(1'b1, 1'b0, 1'b1, 1'b0);
    u_host.load(1'b0, PT);
    wait_done(1'b1);
    u_host.set_mode(1'b0, 1'b0, 1'b0, 1'b0);
    expect_block(CT);
    $display("test auto start finished");
  endtask

  initial begin
    rstn = 1'b0;
    repeat (4) @(negedge mclk);
    rstn = 1'b1;
    test_reset();
    test_encrypt();
    test_decrypt();
    test_xor();
    test_auto();
    close_out();
  end
endmodule
